// [design/sta_pkg.sv]
package sta_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_POST = 8'h08;
    localparam logic [7:0] ADDR_TMO = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_RDADDR = 8'h14;
    localparam logic [7:0] ADDR_RDDATA = 8'h18;
    // control field positions
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_SLOPE_BIT = 2;
    localparam int CTRL_FALL_BIT = 3;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_ARM_BIT = 8;
    localparam int CTRL_STOP_BIT = 9;
    // buffer geometry
    localparam int BUF_DEPTH = 256;
    localparam int BUF_AW = 8;
    localparam int POST_W = 16;
    localparam logic [POST_W-1:0] POST_MAX = 16'h8000;
    localparam logic [POST_W-1:0] POST_RST = 16'h0080;
    // reset values
    localparam logic [9:0] CTRL_RST = 10'h000;
    localparam logic [7:0] LEVEL_RST = 8'h80;
    localparam logic [7:0] SLOPE_RST = 8'h10;
    localparam logic [31:0] TMO_RST = 32'h0001_0000;
    // threshold used when a digital source is compared
    localparam logic [7:0] DIG_LEVEL = 8'h80;
    // trigger sources
    localparam logic [3:0] SRC_ANA1 = 4'h0;
    localparam logic [3:0] SRC_ANA2 = 4'h1;
    localparam logic [3:0] SRC_DIG0 = 4'h2;
    localparam logic [3:0] SRC_EXT = 4'ha;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // arming types
    typedef enum logic [1:0] {
        TYPE_NORMAL = 2'b00,
        TYPE_SINGLE = 2'b01,
        TYPE_AUTO = 2'b10,
        TYPE_FREE = 2'b11
    } sta_type_e;

    // acquisition states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_POST = 2'b10
    } sta_state_e;
endpackage

// [design/sta_trigger_acq.sv]
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
module sta_trigger_acq
    import sta_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // sample inputs
    input wire logic sampleStb,
    input wire logic [7:0] ana1In,
    input wire logic [7:0] ana2In,
    input wire logic [7:0] digIn,
    input wire logic extTrigIn,
    // status outputs
    output logic captureDone,
    output logic acquiring,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // configuration registers
    logic [1:0] typeSel_r;
    logic slopeMode_r;
    logic falling_r;
    logic [3:0] srcSel_r;
    logic [7:0] level_r;
    logic [7:0] slopeThr_r;
    logic [POST_W-1:0] postCnt_r;
    logic [31:0] timeout_r;
    logic [BUF_AW-1:0] rdAddr_r;
    // acquisition state
    sta_state_e state_r;
    logic [BUF_AW-1:0] wrPtr_r;
    logic [BUF_AW-1:0] trigAddr_r;
    logic [POST_W-1:0] postLeft_r;
    logic [31:0] tmoCnt_r;
    logic tmoHit_r;
    logic done_r;
    logic wasTrig_r;
    logic [7:0] prevSrc_r;
    logic [23:0] sampleMem [BUF_DEPTH];
    // bus state
    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    logic armReq;
    logic stopReq;
    // trigger datapath
    logic [7:0] srcNow;
    logic srcDigital;
    logic [7:0] cmpLevel;
    logic [8:0] stepUp;
    logic [8:0] stepDown;
    logic edgeHit;
    logic slopeHit;
    logic trigHit;
    logic forceTrig;
    logic [31:0] ctrlWord;

    // source select; ext behaves as a digital line
    // source mux
    always_comb begin
        srcNow = ana1In;
        srcDigital = 1'b0;
        if (srcSel_r == SRC_ANA2) begin
            srcNow = ana2In;
        end else if (srcSel_r == SRC_EXT) begin
            srcNow = {8{extTrigIn}};
            srcDigital = 1'b1;
        end else if (srcSel_r >= SRC_DIG0 && srcSel_r < SRC_EXT) begin
            srcNow = {8{digIn[3'(srcSel_r - SRC_DIG0)]}};
            srcDigital = 1'b1;
        end
    end

    assign cmpLevel = srcDigital ? DIG_LEVEL : level_r;
    assign edgeHit = falling_r ? (prevSrc_r >= cmpLevel && srcNow < cmpLevel)
                               : (prevSrc_r < cmpLevel && srcNow >= cmpLevel);
    assign stepUp = {1'b0, srcNow} - {1'b0, prevSrc_r};
    assign stepDown = {1'b0, prevSrc_r} - {1'b0, srcNow};
    assign slopeHit = falling_r ? (!stepDown[8] && stepDown[7:0] > slopeThr_r)
                                : (!stepUp[8] && stepUp[7:0] > slopeThr_r);
    // digital sources fall back to edge
    assign trigHit = (slopeMode_r && !srcDigital) ? slopeHit : edgeHit;
    // free type forces; auto forced by timeout
    assign forceTrig = (typeSel_r == TYPE_FREE) || (typeSel_r == TYPE_AUTO && tmoHit_r);

    // previous source sample for edge and slope
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevSrc_r <= 8'h00;
        end else if (sampleStb) begin
            prevSrc_r <= srcNow;
        end
    end

    // circular buffer write on every sample while running
    always_ff @(posedge core_clk) begin
        if (sampleStb && state_r != ST_IDLE) begin
            sampleMem[wrPtr_r] <= {digIn, ana2In, ana1In};
        end
    end

    // acquisition sequencer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            wrPtr_r <= 8'h00;
            trigAddr_r <= 8'h00;
            postLeft_r <= 16'h0000;
            done_r <= 1'b0;
            wasTrig_r <= 1'b0;
            captureDone <= 1'b0;
        end else begin
            captureDone <= 1'b0;
            if (stopReq) begin
                state_r <= ST_IDLE;
            end else if (armReq) begin
                state_r <= ST_WAIT;
                done_r <= 1'b0;
            end else if (sampleStb && state_r != ST_IDLE) begin
                wrPtr_r <= wrPtr_r + 8'h01;
                case (state_r)
                    ST_WAIT: begin
                        // only a detected event or an allowed force
                        if (trigHit || forceTrig) begin
                            trigAddr_r <= wrPtr_r;
                            wasTrig_r <= trigHit && typeSel_r != TYPE_FREE;
                            postLeft_r <= postCnt_r;
                            if (postCnt_r == 16'h0000) begin
                                captureDone <= 1'b1;
                                done_r <= 1'b1;
                                state_r <= (typeSel_r == TYPE_SINGLE) ? ST_IDLE : ST_WAIT;
                            end else begin
                                state_r <= ST_POST;
                            end
                        end
                    end
                    ST_POST: begin
                        // count post samples; full depth wraps once
                        postLeft_r <= postLeft_r - 16'h0001;
                        if (postLeft_r == 16'h0001) begin
                            captureDone <= 1'b1;
                            done_r <= 1'b1;
                            state_r <= (typeSel_r == TYPE_SINGLE) ? ST_IDLE : ST_WAIT;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // auto timeout restarted at each arm and capture
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmoCnt_r <= 32'h0000_0000;
            tmoHit_r <= 1'b0;
        end else if (armReq || state_r != ST_WAIT || (sampleStb && (trigHit || forceTrig))) begin
            tmoCnt_r <= 32'h0000_0000;
            tmoHit_r <= 1'b0;
        end else if (tmoCnt_r >= timeout_r) begin
            tmoHit_r <= 1'b1;
        end else begin
            tmoCnt_r <= tmoCnt_r + 32'h0000_0001;
        end
    end

    assign acquiring = (state_r != ST_IDLE);

    // bus write handshakes; address and data in either order
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign armReq = doWrite && awAddr_r == ADDR_CTRL && wStrb_r[1] && wData_r[CTRL_ARM_BIT];
    assign stopReq = doWrite && awAddr_r == ADDR_CTRL && wStrb_r[1] && wData_r[CTRL_STOP_BIT];

    // capture of write channels and response
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_r <= ADDR_RDADDR) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration register writes
    // post count resets to half depth
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {falling_r, slopeMode_r, typeSel_r} <= CTRL_RST[3:0];
            srcSel_r <= CTRL_RST[7:4];
            level_r <= LEVEL_RST;
            slopeThr_r <= SLOPE_RST;
            postCnt_r <= POST_RST;
            timeout_r <= TMO_RST;
            rdAddr_r <= 8'h00;
        end else if (doWrite) begin
            case (awAddr_r)
                ADDR_CTRL: begin
                    if (wStrb_r[0]) begin
                        typeSel_r <= wData_r[CTRL_TYPE_LSB +: 2];
                        slopeMode_r <= wData_r[CTRL_SLOPE_BIT];
                        falling_r <= wData_r[CTRL_FALL_BIT];
                        srcSel_r <= (wData_r[CTRL_SRC_LSB +: 4] > SRC_EXT) ? SRC_ANA1
                                                                           : wData_r[CTRL_SRC_LSB +: 4];
                    end
                end
                ADDR_LEVEL: begin
                    if (wStrb_r[0]) level_r <= wData_r[7:0];
                    if (wStrb_r[1]) slopeThr_r <= wData_r[15:8];
                end
                ADDR_POST: begin
                    if (wStrb_r[0] && wStrb_r[1]) begin
                        postCnt_r <= (wData_r[15:0] > POST_MAX) ? POST_MAX : wData_r[15:0];
                    end
                end
                ADDR_TMO: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wStrb_r[i]) timeout_r[i*8 +: 8] <= wData_r[i*8 +: 8];
                    end
                end
                ADDR_RDADDR: begin
                    if (wStrb_r[0]) rdAddr_r <= wData_r[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // control readback
    assign ctrlWord = {22'h000000, 2'b00, srcSel_r, falling_r, slopeMode_r, typeSel_r};

    // bus reads, one cycle answer
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                ADDR_CTRL: s_axi_rdata <= ctrlWord;
                ADDR_LEVEL: s_axi_rdata <= {16'h0000, slopeThr_r, level_r};
                ADDR_POST: s_axi_rdata <= {16'h0000, postCnt_r};
                ADDR_TMO: s_axi_rdata <= timeout_r;
                ADDR_STAT: s_axi_rdata <= {8'h00, wrPtr_r, trigAddr_r, 4'h0, state_r == ST_POST,
                                           wasTrig_r, done_r, acquiring};
                ADDR_RDADDR: s_axi_rdata <= {24'h000000, rdAddr_r};
                ADDR_RDDATA: s_axi_rdata <= {8'h00, sampleMem[rdAddr_r]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [verification/sta_trigger_acq_props.sv]
module sta_trigger_acq_props
    import sta_pkg::*;
(
    // clock and reset
    input logic core_clk,
    input logic sys_rst,
    // samples and status
    input logic sampleStb,
    input logic captureDone,
    input logic acquiring,
    // register bus
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready
);
    logic [1:0] ctrlType_r;
    default clocking cbMain @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // bus transfers taken by the slave
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // arming type as last written, aw and w taken together
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlType_r <= 2'h0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == ADDR_CTRL) begin
            ctrlType_r <= s_axi_wdata[1:0];
        end
    end
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing two cycles after transfer");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data missing one cycle after address");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    a_read_unmapped: assert property (s_rd_taken ##0 (s_axi_araddr[7:2] > ADDR_RDDATA[7:2])
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_done_armed: assert property (captureDone |-> $past(acquiring))
        else $error("capture ended while not armed");
    a_done_sample: assert property (captureDone |-> $past(sampleStb))
        else $error("capture ended without a sample");
    a_single_stops: assert property (captureDone && ctrlType_r == TYPE_SINGLE |-> !acquiring)
        else $error("single capture kept acquiring");
    a_cont_rearm: assert property (captureDone && ctrlType_r != TYPE_SINGLE |-> acquiring)
        else $error("continuous type stopped after capture");
endmodule

bind sta_trigger_acq sta_trigger_acq_props u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .sampleStb(sampleStb), .captureDone(captureDone),
    .acquiring(acquiring), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [verification/testbench.sv]
module testbench
    import sta_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sampleStb = 1'b0, extTrigIn = 1'b0;
    logic [7:0] ana1In = 8'h0, ana2In = 8'h0, digIn = 8'h0, awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rdVal;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, captureDone, acquiring;
    logic [1:0] bresp, rresp, rsp;
    integer seed = 32'h32611a64;
    int errCount = 0, nChecks = 0, doneCnt = 0, cyc = 0;

    sta_trigger_acq u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .sampleStb(sampleStb), .ana1In(ana1In), .ana2In(ana2In),
        .digIn(digIn), .extTrigIn(extTrigIn), .captureDone(captureDone), .acquiring(acquiring),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    // capture pulses counted mid-cycle, away from the edges
    always @(negedge core_clk) if (captureDone === 1'b1) doneCnt++;
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errCount++;
            endSim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic endSim();
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // write: address and data offered together, bready raised late
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aDone, wDone;
        aDone = 0;
        wDone = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aDone && wDone)) begin
            @(posedge core_clk);
            if (!aDone && awready === 1'b1) begin
                aDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        @(posedge core_clk);
        bready <= 1'b1;
        do @(posedge core_clk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    // read: rready raised one cycle after the address is taken
    task automatic rdReg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        @(posedge core_clk);
        rready <= 1'b1;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        rdVal = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    // one sample on every channel; digital lanes follow the top bit
    task automatic samp(input logic [7:0] v);
        sampleStb <= 1'b1;
        ana1In <= v;
        ana2In <= v;
        digIn <= {8{v[7]}};
        extTrigIn <= v[7];
        @(posedge core_clk);
        sampleStb <= 1'b0;
        @(posedge core_clk);
    endtask

    // expected readout word for one sample fed by samp
    function automatic logic [31:0] expSample(input logic [7:0] v);
        return {8'h00, {8{v[7]}}, v, v};
    endfunction

    // arm, feed history, trigger, post samples, then check buffer state
    task automatic cap(input logic [9:0] ctl, input int post, input int nPre, input logic [7:0] pre,
                       input logic [7:0] pm, input logic [7:0] trg);
        int n0;
        logic [7:0] wp0, ta;
        samp(pre);
        wr(ADDR_POST, 32'(post));
        wr(ADDR_CTRL, 32'(ctl) | 32'h100);
        rdReg(ADDR_STAT);
        wp0 = rdVal[23:16];
        n0 = doneCnt;
        repeat (nPre) samp(pre | (8'($random(seed)) & pm));
        samp(trg);
        repeat (post) begin
            chk("early done", doneCnt, n0);
            samp(trg);
        end
        chk("done count", doneCnt, n0 + 1);
        chk("acquiring", acquiring, ctl[1:0] != TYPE_SINGLE);
        rdReg(ADDR_STAT);
        ta = wp0 + 8'(nPre);
        chk("trig addr", rdVal[15:8], ta);
        chk("write ptr", rdVal[23:16], 8'(ta + 1 + post));
        chk("real trig", rdVal[2], 1'b1);
        chk("done flag", rdVal[1], 1'b1);
        wr(ADDR_RDADDR, 32'(ta));
        rdReg(ADDR_RDDATA);
        if (post < 256) chk("sample", rdVal, expSample(trg));
        wr(ADDR_CTRL, 32'(ctl) | 32'h200);
    endtask

    // main sequence
    initial begin
        int k;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdReg(ADDR_POST);
        chk("post reset", rdVal, 32'h80);
        rdReg(8'h1c);
        chk("unmapped read", rsp, RESP_SLVERR);
        wr(8'h20, 32'h0);
        chk("unmapped write", rsp, RESP_SLVERR);
        wr(ADDR_STAT, 32'h0);
        chk("status write", rsp, RESP_OKAY);
        wr(ADDR_POST, 32'h8001);
        rdReg(ADDR_POST);
        chk("post clamp", rdVal, 32'(POST_MAX));
        wr(ADDR_CTRL, 32'hf9);
        rdReg(ADDR_CTRL);
        chk("src clamp", rdVal, 32'h09);
        wr(ADDR_LEVEL, 32'h1080);
        cap(10'h000, 3, 5, 8'h00, 8'h3f, 8'hc0);
        cap(10'h000, 0, 4, 8'h00, 8'h3f, 8'hc0);
        cap(10'h000, 256, 2, 8'h00, 8'h3f, 8'hc0);
        cap(10'h018, 2, 3, 8'h80, 8'h3f, 8'h20);
        cap(10'h004, 1, 3, 8'h40, 8'h00, 8'h51);
        cap(10'h00c, 1, 2, 8'h80, 8'h00, 8'h60);
        wr(ADDR_LEVEL, 32'hff80);
        cap(10'h054, 1, 3, 8'h00, 8'h3f, 8'hc0);
        wr(ADDR_LEVEL, 32'h1080);
        cap(10'h0a0, 1, 2, 8'h00, 8'h3f, 8'hff);
        cap(10'h001, 1, 2, 8'h00, 8'h3f, 8'hc0);
        cap(10'h002, 1, 2, 8'h00, 8'h3f, 8'hc0);
        wr(ADDR_POST, 32'h0);
        wr(ADDR_CTRL, 32'h103);
        k = doneCnt;
        repeat (3) samp(8'($random(seed)));
        chk("free captures", doneCnt, k + 3);
        rdReg(ADDR_STAT);
        chk("free untriggered", rdVal[2], 1'b0);
        wr(ADDR_TMO, 32'd20);
        wr(ADDR_CTRL, 32'h102);
        k = doneCnt;
        repeat (8) @(posedge core_clk);
        samp(8'h10);
        chk("auto early", doneCnt, k);
        repeat (16) @(posedge core_clk);
        samp(8'h10);
        chk("auto forced", doneCnt, k + 1);
        rdReg(ADDR_STAT);
        chk("auto untriggered", rdVal[2], 1'b0);
        endSim();
    end
endmodule
